// *** core/cgbt_params.svh ***
// Constants for the CAN global configuration and bit-timing block
`ifndef CGBT_PARAMS_SVH
`define CGBT_PARAMS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define CGBT_OFS_CONFIG 8'h00
`define CGBT_OFS_TIMING 8'h04
`define CGBT_OFS_STATUS 8'h08
`define CGBT_OFS_PEND 8'h0C
`define CGBT_OFS_LOCK 8'h10
`define CGBT_OFS_STAMP 8'h14

// ************************************************************
// Global configuration fields and reset values
// ************************************************************
`define CGBT_B_EN 0
`define CGBT_B_TXPOL 1
`define CGBT_B_RXPOL 2
`define CGBT_B_HOLD 3
`define CGBT_B_TSYNC 4
`define CGBT_B_ORDER 5
`define CGBT_B_LISTEN 6
`define CGBT_B_SKIPACK 7
`define CGBT_B_LOOP 8
`define CGBT_B_INTERNAL 9
`define CGBT_B_DIAG 10
`define CGBT_B_EITYPE 11
`define CGBT_CFG_MASK 16'h0FFF
`define CGBT_CFG_RESET 16'h0000
`define CGBT_TIM_RESET 16'h0000

// ************************************************************
// Timing and counter constants
// ************************************************************
`define CGBT_PSC_CAP 7'h7E
`define CGBT_DIV_MAX 8'h80
`define CGBT_TEC_STEP 9'h008
`define CGBT_PASSIVE_LVL 8'h80
`define CGBT_NUM_BUF 15
`define CGBT_LAST_BYTE 3'h7

`endif

// *** core/cgbt_pkg.sv ***
// Types shared by the CAN configuration and bit-timing files
package cgbt_pkg;
  // Bit segment one-hot states
  typedef enum logic [2:0] {
    CGBT_SEG_SYNC = 3'h1,
    CGBT_SEG_ONE = 3'h2,
    CGBT_SEG_TWO = 3'h4
  } cgbt_seg_t;
  // Node error state encoding
  typedef enum logic [1:0] {
    CGBT_NODE_ACTIVE = 2'h0,
    CGBT_NODE_PASSIVE = 2'h1,
    CGBT_NODE_BUSOFF = 2'h2
  } cgbt_node_t;
endpackage

// *** core/cgbt_bit_timing.sv ***
// Prescaler and bit segment sequencer with resynchronisation
`timescale 1ns/1ps
`include "cgbt_params.svh"
module cgbt_bit_timing
  import cgbt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration
  input wire logic run,
  input wire logic [6:0] bit_rate_prescaler,
  input wire logic [1:0] resync_jump_width,
  input wire logic [3:0] seg1,
  input wire logic [2:0] seg2,
  // Receive level, dominant high
  input wire logic rxDom,
  // Timing events
  output logic tqTick,
  output logic bitStart,
  output logic samplePulse
);
  // Smaller of two quantum counts
  function automatic logic [4:0] minq(input logic [4:0] a,
                                      input logic [4:0] b);
    minq = (a < b) ? a : b;
  endfunction

  logic [6:0] pre; // Prescaler count
  logic [4:0] q; // Quanta spent in segment
  logic [4:0] lim; // Current segment length
  logic prevDom; // Last receive level
  logic edgePend; // Edge seen since last quantum
  logic resynced; // One resync per bit
  cgbt_seg_t seg;
  cgbt_seg_t next_seg;
  logic [4:0] next_lim;

  // ************************************************************
  // Quantum generation
  // ************************************************************
  wire logic [7:0] divisor = (bit_rate_prescaler >= `CGBT_PSC_CAP) ? `CGBT_DIV_MAX
                             : {1'b0, bit_rate_prescaler} + 8'h02;
  wire logic [4:0] sjwq = {3'h0, resync_jump_width} + 5'h01;
  wire logic [4:0] len1 = {1'b0, seg1} + 5'h01;
  wire logic [4:0] len2 = {2'h0, seg2} + 5'h01;
  wire logic [4:0] qNext = q + 5'h01;
  wire logic fallEdge = rxDom & ~prevDom;
  wire logic doSync = edgePend & ~resynced;
  // Catch up at once when a smaller divisor lands mid-count
  assign tqTick = run && ({1'b0, pre} >= divisor - 8'h01);
  // Quantum that opens the sync segment of the next bit
  assign bitStart = tqTick && seg == CGBT_SEG_TWO
                    && next_seg == CGBT_SEG_SYNC;
  assign samplePulse = tqTick && seg == CGBT_SEG_ONE && qNext == next_lim;

  // Segment sequencing, quantum by quantum
  always_comb
  begin
    next_seg = seg;
    next_lim = lim;
    case (seg)
      CGBT_SEG_SYNC: next_seg = CGBT_SEG_ONE;
      CGBT_SEG_ONE:
      begin
        // Late edge lengthens the first segment
        if (doSync)
          next_lim = lim + minq(qNext, sjwq);
        if (qNext == next_lim)
          next_seg = CGBT_SEG_TWO; // Sample point
      end
      CGBT_SEG_TWO:
      begin
        // Early edge shortens the second segment
        if (doSync)
          next_lim = (lim - q <= sjwq) ? qNext : lim - sjwq;
        if (qNext >= next_lim)
          next_seg = CGBT_SEG_SYNC;
      end
      default: next_seg = CGBT_SEG_SYNC;
    endcase
  end

  // Prescaler counter, cleared while stopped
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pre <= 7'h00;
    else if (!run || tqTick)
      pre <= 7'h00;
    else
      pre <= pre + 7'h01;
  end

  // Segment state and lengths
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seg <= CGBT_SEG_SYNC;
      q <= 5'h00;
      lim <= 5'h01;
      prevDom <= 1'b0;
      edgePend <= 1'b0;
      resynced <= 1'b0;
    end
    else if (!run)
    begin
      seg <= CGBT_SEG_SYNC;
      q <= 5'h00;
      lim <= 5'h01;
      prevDom <= 1'b0;
      edgePend <= 1'b0;
      resynced <= 1'b0;
    end
    else
    begin
      prevDom <= rxDom;
      if (tqTick)
      begin
        seg <= next_seg;
        edgePend <= fallEdge;
        if (seg != CGBT_SEG_SYNC && doSync)
          resynced <= 1'b1;
        if (next_seg != seg)
        begin
          q <= 5'h00;
          lim <= (next_seg == CGBT_SEG_TWO) ? len2 : len1;
          if (next_seg == CGBT_SEG_SYNC)
            resynced <= 1'b0;
        end
        else
        begin
          q <= qNext;
          lim <= next_lim;
        end
      end
      else if (fallEdge)
        edgePend <= 1'b1;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  pscMax_a: assert property (@(posedge clk) disable iff (!rstn)
    (run && pre == 7'h7F) |-> $past(divisor) == `CGBT_DIV_MAX)
    else $error("prescaler passed the 128 divisor");
endmodule

// *** core/cgbt_top.sv ***
// CAN global configuration, bit timing and mode control block
`timescale 1ns/1ps
`include "cgbt_params.svh"
module cgbt_top
  import cgbt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // CAN pins
  input wire logic busRxPin,
  output logic busTxPin,
  // Protocol engine requests
  input wire logic coreTxDom,
  input wire logic coreAckDrive,
  input wire logic ownFrame,
  input wire logic ackSlot,
  input wire logic ackDomSeen,
  input wire logic [2:0] byteIdx,
  // Protocol engine events
  input wire logic rxOkEvt,
  input wire logic txOkEvt,
  input wire logic [3:0] evtBuf,
  input wire logic busErrEvt,
  input wire logic txErrInc,
  input wire logic rxErrInc,
  input wire logic bufRelease,
  input wire logic [3:0] relBuf,
  // Status towards the protocol engine
  output logic moduleRun,
  output logic rxDom,
  output logic bitStart,
  output logic samplePulse,
  output logic sampleBit,
  output logic listenMode,
  output logic ignoreAck,
  output logic loopMode,
  output logic hiddenWrEn,
  output logic txValid,
  output logic ackErr,
  output logic [2:0] dataAddr,
  output logic [14:0] lockedBuf,
  output logic errPending,
  output logic [1:0] nodeState
);
  // Node state from the two error counters
  function automatic cgbt_node_t nodeOf(input logic [8:0] t,
                                        input logic [7:0] r,
                                        input logic passive);
    if (t[8])
      nodeOf = CGBT_NODE_BUSOFF;
    else if (passive || t[7:0] >= `CGBT_PASSIVE_LVL
             || r >= `CGBT_PASSIVE_LVL)
      nodeOf = CGBT_NODE_PASSIVE;
    else
      nodeOf = CGBT_NODE_ACTIVE;
  endfunction

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [15:0] cfg; // Global configuration
  logic [15:0] tim; // Bit timing
  logic [8:0] tx_error_count; // Transmit error count
  logic [7:0] rx_error_count; // Receive error count
  logic [15:0] tsCount; // Time stamp counter
  logic dWr; // Data phase is a write
  logic [7:0] dAddr; // Data phase address
  logic rxS1, rxS2; // Receive pin synchroniser
  logic txDom; // Internal transmit level
  logic [8:0] next_tec;
  logic [7:0] next_rec;

  // ************************************************************
  // Mode decoding
  // ************************************************************
  wire logic en = cfg[`CGBT_B_EN];
  wire logic diag = cfg[`CGBT_B_DIAG];
  wire logic lo = diag & cfg[`CGBT_B_LISTEN];
  wire logic ign = diag & cfg[`CGBT_B_SKIPACK];
  wire logic lpb = diag & cfg[`CGBT_B_LOOP];
  wire logic intl = diag & cfg[`CGBT_B_INTERNAL];
  // No dominant drive at all in listen-only
  // Own frame not acknowledged by itself in loop mode
  wire logic next_txDom = en & ~lo
    & (coreTxDom | (coreAckDrive & ~(lpb & ownFrame)));
  // Pin stays recessive while looped inside
  wire logic pinDom = txDom & ~intl;
  wire logic rxLevel = cfg[`CGBT_B_RXPOL] ? rxS2 : ~rxS2;
  wire logic next_rxDom = intl ? txDom : rxLevel;
  wire logic bufZero = (rxOkEvt | txOkEvt) && evtBuf == 4'h0;
  wire logic tsClear = !en || (cfg[`CGBT_B_TSYNC] && bufZero);
  wire logic errInc = (txErrInc & ~lo) | rxErrInc;
  wire cgbt_node_t curNode = nodeOf(tx_error_count, rx_error_count, lo);
  wire cgbt_node_t newNode = nodeOf(next_tec, next_rec, lo);
  wire logic stateChg = errInc && newNode != curNode;
  // Every error or only state changes
  wire logic pendSet = en & (cfg[`CGBT_B_EITYPE] ? stateChg : busErrEvt);
  wire logic btStart, btSample;

  // ************************************************************
  // Bus decoding
  // ************************************************************
  wire logic aValid = hsel & htrans[1] & hready;
  wire logic [7:0] aAddr = haddr[7:0];
  wire logic wCfg = dWr && dAddr == `CGBT_OFS_CONFIG;
  wire logic wTim = dWr && dAddr == `CGBT_OFS_TIMING;
  wire logic wPend = dWr && dAddr == `CGBT_OFS_PEND && hwdata[0];
  wire logic [31:0] rdMux =
    (aAddr == `CGBT_OFS_CONFIG) ? {16'h0000, cfg} :
    (aAddr == `CGBT_OFS_TIMING) ? {16'h0000, tim} :
    (aAddr == `CGBT_OFS_STATUS) ? {6'h00, curNode, rx_error_count, 7'h00, tx_error_count} :
    (aAddr == `CGBT_OFS_PEND) ? {31'h0000_0000, errPending} :
    (aAddr == `CGBT_OFS_LOCK) ? {17'h0_0000, lockedBuf} :
    (aAddr == `CGBT_OFS_STAMP) ? {16'h0000, tsCount} : 32'h0000_0000;
  wire logic [14:0] lockSet = (rxOkEvt && cfg[`CGBT_B_HOLD]
    && evtBuf < 4'hF) ? 15'h0001 << evtBuf : 15'h0000;
  wire logic [14:0] lockClr = (bufRelease && relBuf < 4'hF)
    ? 15'h0001 << relBuf : 15'h0000;

  // Error counter arithmetic, saturating
  always_comb
  begin
    next_tec = tx_error_count;
    next_rec = rx_error_count;
    if (txErrInc && !lo && !tx_error_count[8])
      next_tec = tx_error_count + `CGBT_TEC_STEP;
    else if (txOkEvt && tx_error_count != 9'h000)
      next_tec = tx_error_count - 9'h001;
    if (rxErrInc && rx_error_count != 8'hFF)
      next_rec = rx_error_count + 8'h01;
    else if (rxOkEvt && rx_error_count != 8'h00)
      next_rec = rx_error_count - 8'h01;
  end

  // Bit timing sequencer, stopped while disabled
  cgbt_bit_timing u_timing (
    .clk(clk),
    .rstn(rstn),
    .run(en),
    .bit_rate_prescaler(tim[15:9]),
    .resync_jump_width(tim[8:7]),
    .seg1(tim[6:3]),
    .seg2(tim[2:0]),
    .rxDom(rxDom),
    .tqTick(),
    .bitStart(btStart),
    .samplePulse(btSample)
  );

  // Bus phase capture and answer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dWr <= 1'b0;
      dAddr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      dWr <= aValid & hwrite;
      dAddr <= aAddr;
      if (aValid && !hwrite)
        hrdata <= rdMux;
    end
  end

  // Software registers, zero after reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg <= `CGBT_CFG_RESET;
      tim <= `CGBT_TIM_RESET;
    end
    else
    begin
      if (wCfg)
        cfg <= hwdata[15:0] & `CGBT_CFG_MASK;
      if (wTim)
        tim <= hwdata[15:0];
    end
  end

  // Error counters and stamp, cleared while disabled
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_error_count <= 9'h000;
      rx_error_count <= 8'h00;
      tsCount <= 16'h0000;
    end
    else
    begin
      tx_error_count <= en ? next_tec : 9'h000;
      rx_error_count <= en ? next_rec : 8'h00;
      if (tsClear)
        tsCount <= 16'h0000;
      else if (btStart)
        tsCount <= tsCount + 16'h0001;
    end
  end

  // Buffer locks and pending flag, set beats clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lockedBuf <= 15'h0000;
      errPending <= 1'b0;
      nodeState <= 2'h0;
    end
    else
    begin
      lockedBuf <= en ? (lockSet | (lockedBuf & ~lockClr)) : 15'h0000;
      errPending <= pendSet | (errPending & ~wPend);
      nodeState <= en ? newNode : CGBT_NODE_ACTIVE;
    end
  end

  // Pin paths, receive synchroniser and internal loop
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
      txDom <= 1'b0;
      busTxPin <= 1'b1;
      rxDom <= 1'b0;
    end
    else
    begin
      rxS1 <= busRxPin;
      rxS2 <= rxS1;
      txDom <= next_txDom;
      busTxPin <= cfg[`CGBT_B_TXPOL] ? pinDom : ~pinDom;
      rxDom <= next_rxDom;
    end
  end

  // Registered status towards the engine
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      moduleRun <= 1'b0;
      bitStart <= 1'b0;
      samplePulse <= 1'b0;
      sampleBit <= 1'b0;
      {listenMode, ignoreAck, loopMode, hiddenWrEn} <= 4'h0;
      txValid <= 1'b0;
      ackErr <= 1'b0;
      dataAddr <= 3'h0;
    end
    else
    begin
      moduleRun <= en;
      bitStart <= btStart;
      samplePulse <= btSample;
      if (btSample)
        sampleBit <= rxDom;
      {listenMode, ignoreAck, loopMode, hiddenWrEn} <= {lo, ign, lpb, diag};
      txValid <= ackSlot & (ackDomSeen | ign);
      ackErr <= ackSlot & ~ackDomSeen & ~ign;
      dataAddr <= cfg[`CGBT_B_ORDER] ? byteIdx
                  : `CGBT_LAST_BYTE - byteIdx;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence bufZeroDone;
    en && cfg[`CGBT_B_TSYNC] && bufZero;
  endsequence

  disableClear_a: assert property (!en |=> tx_error_count == 9'h000
    && rx_error_count == 8'h00 && lockedBuf == 15'h0000)
    else $error("counters not cleared while disabled");
  listenQuiet_a: assert property (lo ##1 lo |=>
    busTxPin == !$past(cfg[`CGBT_B_TXPOL]))
    else $error("dominant drive in listen-only");
  rxPolarity_a: assert property (!intl && $stable(cfg) [*4] |->
    rxDom == (cfg[`CGBT_B_RXPOL] ? $past(busRxPin, 3)
              : !$past(busRxPin, 3)))
    else $error("receive polarity wrong");
  lockHold_a: assert property (!cfg[`CGBT_B_HOLD]
    ##1 !cfg[`CGBT_B_HOLD] && lockedBuf == 15'h0000 |=>
    lockedBuf == 15'h0000)
    else $error("buffer locked with lock off");
  stampSync_a: assert property (bufZeroDone |=> tsCount == 16'h0000)
    else $error("stamp not cleared on buffer zero");
  ackWaive_a: assert property (ackSlot && !ackDomSeen && ign
    |=> txValid && !ackErr)
    else $error("unacknowledged frame not waived");
  loopInner_a: assert property (intl ##1 intl |=>
    rxDom == $past(txDom) && busTxPin == !$past(cfg[`CGBT_B_TXPOL]))
    else $error("internal loop not routed");
  diagGate_a: assert property (!diag |=>
    !listenMode && !ignoreAck && !loopMode && !hiddenWrEn)
    else $error("diagnostic feature active while gated");
  errEvery_a: assert property (en && !cfg[`CGBT_B_EITYPE]
    && busErrEvt |=> errPending)
    else $error("error pending not set");
endmodule

// *** tb/cgbt_bus_model.sv ***
// Behavioural CAN bus with transceiver, seen from the controller pins
`timescale 1ns/1ps
module cgbt_bus_model
(
  // Clock
  input wire logic clk,
  // Controller pins
  input wire logic txPin,
  output logic rxPin,
  // Bench controls: pin polarities, foreign node, loop delay
  input wire logic txPolHigh,
  input wire logic rxPolHigh,
  input wire logic otherDom,
  input wire logic [1:0] lag
);
  // Wired-AND bus: any dominant node wins
  logic busDom;
  // Transceiver and wire delay line
  logic [2:0] pipe = 3'h0;
  // Delay taps, index is the lag in clocks
  logic [3:0] taps;
  assign busDom = (txPin == txPolHigh) || otherDom;
  assign taps = {pipe, busDom};
  // Shift the bus level, longest tap three clocks
  always @(posedge clk)
  begin
    pipe <= {pipe[1:0], busDom};
  end
  // Dominant shown at the level the receive polarity asks for
  assign rxPin = taps[lag] ? rxPolHigh : !rxPolHigh;
endmodule

// *** tb/can_global_config_bit_timing_tb.sv ***
// Self-checking bench for the CAN configuration and bit-timing block
`timescale 1ns/1ps
`include "cgbt_params.svh"
module can_global_config_bit_timing_tb
  import cgbt_pkg::*;
;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic clk, rstn, hsel, hwrite, hreadyout, hresp, busRxPin, busTxPin;
  logic [1:0] htrans, lag, nodeState;
  logic [31:0] haddr, hwdata, hrdata;
  logic coreTxDom, coreAckDrive, ownFrame, ackSlot, ackDomSeen;
  logic rxOkEvt, txOkEvt, busErrEvt, txErrInc, rxErrInc, bufRelease;
  logic [2:0] byteIdx, dataAddr;
  logic [3:0] evtBuf, relBuf;
  logic moduleRun, rxDom, bitStart, samplePulse, sampleBit, listenMode;
  logic ignoreAck, loopMode, hiddenWrEn, txValid, ackErr, errPending;
  logic [14:0] lockedBuf;
  logic txPolHigh, rxPolHigh, otherDom;
  int errors = 0;
  int numChecks = 0;

  cgbt_top dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .busRxPin(busRxPin), .busTxPin(busTxPin),
    .coreTxDom(coreTxDom), .coreAckDrive(coreAckDrive),
    .ownFrame(ownFrame), .ackSlot(ackSlot), .ackDomSeen(ackDomSeen),
    .byteIdx(byteIdx), .rxOkEvt(rxOkEvt), .txOkEvt(txOkEvt),
    .evtBuf(evtBuf), .busErrEvt(busErrEvt), .txErrInc(txErrInc),
    .rxErrInc(rxErrInc), .bufRelease(bufRelease), .relBuf(relBuf),
    .moduleRun(moduleRun), .rxDom(rxDom), .bitStart(bitStart),
    .samplePulse(samplePulse), .sampleBit(sampleBit),
    .listenMode(listenMode), .ignoreAck(ignoreAck), .loopMode(loopMode),
    .hiddenWrEn(hiddenWrEn), .txValid(txValid), .ackErr(ackErr),
    .dataAddr(dataAddr), .lockedBuf(lockedBuf), .errPending(errPending),
    .nodeState(nodeState));

  cgbt_bus_model bus_u (.clk(clk), .txPin(busTxPin), .rxPin(busRxPin),
    .txPolHigh(txPolHigh), .rxPolHigh(rxPolHigh), .otherDom(otherDom),
    .lag(lag));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    numChecks++;
    if (seen !== want)
    begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic endSim();
    if (errors == 0 && numChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Wait edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One bus phase: wait for ready at an edge, take read data there
  task automatic busStep(output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    q = hrdata;
    #1;
    if (n >= 50)
    begin
      errors++;
      endSim();
    end
  endtask

  // Single word transfer, address phase then data phase
  task automatic regAccess(input logic wr, input logic [7:0] a,
                           input logic [15:0] d, output logic [31:0] q);
    logic [31:0] unused;
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    busStep(unused);
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    busStep(q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    regAccess(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] q;
    regAccess(1'b0, a, 16'h0000, q);
    check(q, want);
  endtask

  // Event pulse: 0 rx ok, 1 tx ok, 2 bus error, 3 tx inc, 4 rx inc, 5 free
  task automatic fire(input int k, input logic [3:0] b);
    evtBuf <= b;
    relBuf <= b;
    case (k)
      0: rxOkEvt <= 1'b1;
      1: txOkEvt <= 1'b1;
      2: busErrEvt <= 1'b1;
      3: txErrInc <= 1'b1;
      4: rxErrInc <= 1'b1;
      default: bufRelease <= 1'b1;
    endcase
    tick(1);
    {rxOkEvt, txOkEvt, busErrEvt, txErrInc, rxErrInc, bufRelease} <= 6'h00;
    tick(1);
  endtask

  // Acknowledge slot of an own frame, judged one clock later
  task automatic ack(input logic dom, input logic v, input logic e);
    ackDomSeen <= dom;
    ackSlot <= 1'b1;
    tick(1);
    ackSlot <= 1'b0;
    check({txValid, ackErr}, {v, e});
    tick(1);
  endtask

  // Clocks until bitStart (smp 0) or samplePulse (smp 1)
  task automatic cyclesTo(input bit smp, output int n);
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while ((smp ? samplePulse : bitStart) !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      errors++;
      endSim();
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic tReset();
    rstn <= 1'b0;
    tick(20);
    rstn <= 1'b1;
    tick(1);
    check({busTxPin, moduleRun, hresp}, 3'b100);
    rdChk(`CGBT_OFS_CONFIG, 32'h0000_0000);
    rdChk(`CGBT_OFS_TIMING, 32'h0000_0000);
  endtask

  task automatic tRegs();
    wr(`CGBT_OFS_CONFIG, 16'hFFFF);
    rdChk(`CGBT_OFS_CONFIG, 32'h0000_0FFF);
    wr(`CGBT_OFS_TIMING, 16'hFFFF);
    rdChk(`CGBT_OFS_TIMING, 32'h0000_FFFF);
    wr(8'h40, 16'hFFFF);
    rdChk(8'h40, 32'h0000_0000);
    wr(`CGBT_OFS_TIMING, 16'h0008);
  endtask

  task automatic tPins();
    lag <= 2'h3;
    for (int p = 0; p < 4; p++)
    begin
      txPolHigh <= p[0];
      rxPolHigh <= p[1];
      wr(`CGBT_OFS_CONFIG, 16'h0001 | 16'(p << 1));
      check(moduleRun, 1'b1);
      for (int d = 0; d < 3; d++)
      begin
        coreTxDom <= (d == 1);
        otherDom <= (d == 2);
        tick(20);
        check(busTxPin, (d == 1) ? p[0] : !p[0]);
        check(rxDom, d != 0);
        check(sampleBit, d != 0);
      end
    end
    {coreTxDom, otherDom, txPolHigh, rxPolHigh} <= 4'h0;
    lag <= 2'h0;
  endtask

  task automatic tOrder();
    for (int o = 0; o < 2; o++)
    begin
      wr(`CGBT_OFS_CONFIG, 16'h0001 | 16'(o << 5));
      for (int i = 0; i < 8; i++)
      begin
        byteIdx <= i[2:0];
        tick(1);
        check(dataAddr, o ? i : 7 - i);
      end
    end
  endtask

  task automatic tDiag();
    {coreTxDom, coreAckDrive, ownFrame} <= 3'h7;
    wr(`CGBT_OFS_CONFIG, 16'h03C1);
    tick(3);
    check({listenMode, ignoreAck, loopMode, hiddenWrEn}, 4'h0);
    check(busTxPin, 1'b0);
    ack(1'b0, 1'b0, 1'b1);
    ack(1'b1, 1'b1, 1'b0);
    wr(`CGBT_OFS_CONFIG, 16'h0441);
    tick(3);
    check({listenMode, busTxPin}, 2'b11);
    check(nodeState, CGBT_NODE_PASSIVE);
    wr(`CGBT_OFS_CONFIG, 16'h0481);
    tick(1);
    check(ignoreAck, 1'b1);
    ack(1'b0, 1'b1, 1'b0);
    coreTxDom <= 1'b0;
    wr(`CGBT_OFS_CONFIG, 16'h0501);
    tick(3);
    check({loopMode, busTxPin}, 2'b11);
    ack(1'b0, 1'b0, 1'b1);
    coreTxDom <= 1'b1;
    wr(`CGBT_OFS_CONFIG, 16'h0601);
    tick(10);
    check({busTxPin, rxDom, hiddenWrEn}, 3'b111);
    {coreTxDom, coreAckDrive, ownFrame} <= 3'h0;
  endtask

  task automatic tLock();
    wr(`CGBT_OFS_CONFIG, 16'h0009);
    fire(0, 4'hE);
    check(lockedBuf, 15'h4000);
    rdChk(`CGBT_OFS_LOCK, 32'h0000_4000);
    fire(5, 4'hE);
    check(lockedBuf, 15'h0000);
    wr(`CGBT_OFS_CONFIG, 16'h0001);
    fire(0, 4'h3);
    check(lockedBuf, 15'h0000);
  endtask

  task automatic tErr();
    fire(2, 4'hF);
    check(errPending, 1'b1);
    wr(`CGBT_OFS_PEND, 16'h0001);
    tick(1);
    check(errPending, 1'b0);
    wr(`CGBT_OFS_CONFIG, 16'h0801);
    fire(2, 4'hF);
    fire(4, 4'hF);
    for (int i = 0; i < 15; i++)
      fire(3, 4'hF);
    check(errPending, 1'b0);
    fire(3, 4'hF);
    check(errPending, 1'b1);
    rdChk(`CGBT_OFS_STATUS, 32'h0101_0080);
    wr(`CGBT_OFS_CONFIG, 16'h0800);
    tick(2);
    check(moduleRun, 1'b0);
    rdChk(`CGBT_OFS_STATUS, 32'h0000_0000);
    rdChk(`CGBT_OFS_CONFIG, 32'h0000_0800);
  endtask

  task automatic tTiming();
    logic [15:0] tim [5] = '{16'h0008, 16'h007F, 16'h0208, 16'hFC08,
                             16'hFE08};
    int bitLen [5] = '{8, 50, 12, 512, 512};
    int smp [5] = '{6, 34, 9, 384, 384};
    int n, m;
    wr(`CGBT_OFS_CONFIG, 16'h0001);
    for (int i = 0; i < 5; i++)
    begin
      wr(`CGBT_OFS_TIMING, tim[i]);
      cyclesTo(1'b0, n);
      cyclesTo(1'b0, n);
      cyclesTo(1'b1, n);
      check(n, smp[i]);
      cyclesTo(1'b0, m);
      check(n + m, bitLen[i]);
    end
  endtask

  task automatic tStamp();
    logic [31:0] q;
    wr(`CGBT_OFS_TIMING, 16'h0008);
    for (int s = 0; s < 3; s++)
    begin
      wr(`CGBT_OFS_CONFIG, (s == 0) ? 16'h0001 : 16'h0011);
      tick(80);
      fire(s == 1, (s == 2) ? 4'h5 : 4'h0);
      regAccess(1'b0, `CGBT_OFS_STAMP, 16'h0000, q);
      check(q > 32'd4, s != 1);
    end
  endtask

  // Main sequence
  initial
  begin
    {hsel, hwrite} <= 2'h0;
    htrans <= 2'b00;
    haddr <= 32'h0000_0000;
    hwdata <= 32'h0000_0000;
    {coreTxDom, coreAckDrive, ownFrame, ackSlot, ackDomSeen} <= 5'h00;
    {rxOkEvt, txOkEvt, busErrEvt, txErrInc, rxErrInc, bufRelease} <= 6'h00;
    byteIdx <= 3'h0;
    {evtBuf, relBuf} <= 8'h00;
    {txPolHigh, rxPolHigh, otherDom} <= 3'h0;
    lag <= 2'h0;
    tReset();
    tRegs();
    tPins();
    tOrder();
    tDiag();
    tLock();
    tErr();
    tTiming();
    tStamp();
    tReset();
    endSim();
  end
endmodule
